// ===== rtl/edp_pkg.sv
// Purpose: shared constants and types for the page-mode dram host controller
// Assumes: 25 MHz clock; all times rounded to whole cycles of CLK_NS
// Notes: least times round up, longest times round down
package edp_pkg;
	localparam int CLK_NS = 40;
	// device timing figures, in their own units
	localparam int T_RAS_NS = 50;
	localparam int T_RAS_MAX_NS = 10000;
	localparam int T_RP_NS = 30;
	localparam int T_RAC_NS = 50;
	localparam int T_CAS_NS = 8;
	localparam int T_REF_MS = 16;
	localparam int T_PAUSE_US = 200;
	localparam int REF_ROWS = 1024;
	localparam int INIT_CYCLES = 8;
	localparam int SYNC_STAGES = 2;
	// widths
	localparam int ADDR_W = 10;
	localparam int DATA_W = 16;
	localparam int BURST_W = 11;
	localparam int RASC_W = 9;

	function automatic int cdiv(input int a, input int b);
		return (a + b - 1) / b;
	endfunction : cdiv

	// derived cycle counts
	localparam int RAS_MIN_CYC = cdiv(T_RAS_NS, CLK_NS);
	localparam int RAS_MAX_CYC = T_RAS_MAX_NS / CLK_NS;
	localparam int RP_CYC = cdiv(T_RP_NS, CLK_NS);
	// row access plus the synchroniser depth, minus the row cycle already spent
	localparam int RD_CYC = cdiv(T_RAC_NS, CLK_NS) + SYNC_STAGES - 1;
	localparam int WR_CYC = cdiv(T_CAS_NS, CLK_NS);
	localparam int REF_CYC = (T_REF_MS * 1000000) / (REF_ROWS * CLK_NS);
	localparam int PAUSE_CYC = (T_PAUSE_US * 1000) / CLK_NS;
	// page is closed early enough that a last read still ends inside the row maximum
	localparam int RAS_LIM_CYC = RAS_MAX_CYC - RD_CYC - 2;

	typedef struct packed {
		logic wr;
		logic [1:0] be;
		logic [2*ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} edp_req_t;

	typedef struct packed {
		logic ras_n;
		logic lower_lane_column_strobe_n_n;
		logic upper_lane_column_strobe_n_n;
		logic we_n;
		logic oe_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
		logic [1:0] dq_oe;
	} edp_pins_t;
endpackage : edp_pkg

// ===== rtl/edp_tick.sv
// Purpose: free-running divider giving a one-cycle enable every PERIOD cycles
// Assumes: PERIOD of at least 2
// Notes: paces the distributed refresh
`timescale 1ns/1ps
module edp_tick import edp_pkg::*; #(
	parameter int PERIOD = REF_CYC
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	output logic tick_o
);
	localparam int W = $clog2(PERIOD);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic next_tick;

	// wrap counter, pulse on wrap
	always_comb begin
		next_tick = 1'b0;
		next_cnt = cnt + 1'b1;
		if (cnt == W'(PERIOD - 1)) begin
			next_cnt = '0;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt <= '0;
			tick_o <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick_o <= next_tick;
		end
	end
endmodule : edp_tick

// ===== rtl/edp_ctrl.sv
// Purpose: host controller driving an asynchronous page-mode dram through its strobes
// Assumes: one 25 MHz clock; user request port on the same clock; dq pins synchronised
// Notes: all pins registered; distributed refresh plus a full burst after self refresh
// Summary of operation
// - row then column go out on the same ten address lines.
// - a cycle starts at row strobe low, ends when all strobes are high.
// - row strobe stays low at least the minimum active pulse width.
// - row strobe stays high at least the precharge time between cycles.
// - reads run with write strobe high; column address held through the access.
// - write data is driven no later than the column strobe falls.
// - issue 1,024 refreshes every 16 ms.
// - column-before-row refresh: row strobe falls with column strobes already low.
// - self refresh entered by holding a column-before-row refresh for the pulse time.
// - self refresh left by holding row strobe high at least precharge time.
// - after self refresh, burst-refresh all 1,024 rows before normal accesses.
// - page mode: same-row columns accessed by toggling only column strobes.
// - power-on: strobes high, 200 us pause, eight row-strobe cycles.
`timescale 1ns/1ps
module edp_ctrl import edp_pkg::*; #(
	parameter int PAUSE_CYCLES = PAUSE_CYC,
	parameter int SELF_HOLD_CYCLES = 2500
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic req_valid_i,
	input wire edp_req_t req_i,
	output logic req_ready_o,
	output logic rsp_valid_o,
	output logic [DATA_W-1:0] rdata_o,
	input wire logic sleep_i,
	output logic self_refresh_o,
	output logic ras_n_o,
	output logic lower_lane_column_strobe_n_o,
	output logic upper_lane_column_strobe_n_o,
	output logic we_n_o,
	output logic oe_n_o,
	output logic [ADDR_W-1:0] mux_address_lines_o,
	input wire logic [DATA_W-1:0] data_lines_i,
	output logic [DATA_W-1:0] data_lines_o,
	output logic [1:0] data_lines_oe_o
);
	localparam int CNT_W = 24;

	typedef enum logic [3:0] {
		S_PAUSE, S_IDLE, S_ROW, S_COL, S_PAGE, S_PRE, S_CBR_CAS, S_CBR_RAS, S_SELF
	} edp_state_t;

	edp_state_t state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic [RASC_W-1:0] ras_cnt, next_ras_cnt;
	logic [BURST_W-1:0] burst_left, next_burst_left;
	logic [ADDR_W-1:0] open_row, next_open_row;
	edp_req_t cur, next_cur;
	edp_pins_t pins, next_pins;
	logic pend, next_pend;
	logic ref_pend, next_ref_pend;
	logic self_go, next_self_go;
	logic next_ready, next_rsp_valid;
	logic [DATA_W-1:0] next_rdata;
	logic [DATA_W-1:0] dq_s1, dq_s2;
	logic ref_tick, take, row_hit, close_page, col_last;

	// refresh pacing: 1,024 enables per 16 ms
	edp_tick #(.PERIOD(REF_CYC)) u_tick (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.tick_o(ref_tick)
	);

	// pins drive straight from the pin register
	assign ras_n_o = pins.ras_n;
	assign lower_lane_column_strobe_n_o = pins.lower_lane_column_strobe_n_n;
	assign upper_lane_column_strobe_n_o = pins.upper_lane_column_strobe_n_n;
	assign we_n_o = pins.we_n;
	assign oe_n_o = pins.oe_n;
	assign mux_address_lines_o = pins.addr;
	assign data_lines_o = pins.dq;
	assign data_lines_oe_o = pins.dq_oe;

	// helper terms for the sequencer
	assign take = req_valid_i && req_ready_o;
	assign row_hit = cur.addr[2*ADDR_W-1:ADDR_W] == open_row;
	assign close_page = ref_pend || sleep_i || (pend && !row_hit) || (ras_cnt >= RASC_W'(RAS_LIM_CYC));
	assign col_last = cnt == (cur.wr ? CNT_W'(WR_CYC - 1) : CNT_W'(RD_CYC - 1));

	// sequencer next state
	always_comb begin
		next_state = state;
		next_cnt = cnt + 1'b1;
		next_ras_cnt = ras_cnt;
		next_burst_left = burst_left;
		next_open_row = open_row;
		next_cur = cur;
		next_pend = pend;
		next_self_go = self_go;
		next_rsp_valid = 1'b0;
		next_rdata = rdata_o;
		// refresh request: a new tick wins over the clear
		next_ref_pend = ref_tick || (ref_pend && state != S_CBR_CAS);
		if (take) begin
			next_cur = req_i;
			next_pend = 1'b1;
		end
		if (!ras_n_o && ras_cnt != '1) begin
			next_ras_cnt = ras_cnt + 1'b1;
		end
		case (state)
			S_PAUSE: begin
				if (cnt == CNT_W'(PAUSE_CYCLES - 1)) begin
					next_state = S_IDLE;
					next_burst_left = BURST_W'(INIT_CYCLES);
				end
			end
			S_IDLE: begin
				// refresh bursts first, then queued access, then periodic refresh
				if (burst_left != '0) begin
					next_state = S_CBR_CAS;
				end else if (pend) begin
					next_state = S_ROW;
					next_open_row = cur.addr[2*ADDR_W-1:ADDR_W];
				end else if (ref_pend || sleep_i) begin
					next_state = S_CBR_CAS;
					next_self_go = sleep_i;
				end
			end
			S_ROW: begin
				next_state = S_COL;
				next_cnt = '0;
			end
			S_COL: begin
				// strobes and column held until the access completes
				if (col_last) begin
					next_state = S_PAGE;
					next_pend = take;
					next_rsp_valid = 1'b1;
					if (!cur.wr) begin
						next_rdata = dq_s2;
					end
				end
			end
			S_PAGE: begin
				// a page may not close before the minimum active width
				if (close_page && ras_cnt >= RASC_W'(RAS_MIN_CYC - 1)) begin
					next_state = S_PRE;
					next_cnt = '0;
				end else if (pend && row_hit && !close_page) begin
					next_state = S_COL;
					next_cnt = '0;
				end
			end
			S_PRE: begin
				next_ras_cnt = '0;
				if (cnt >= CNT_W'(RP_CYC - 1)) begin
					next_state = S_IDLE;
				end
			end
			S_CBR_CAS: begin
				next_state = S_CBR_RAS;
				next_cnt = '0;
				if (burst_left != '0) begin
					next_burst_left = burst_left - 1'b1;
				end
			end
			S_CBR_RAS: begin
				if (cnt == CNT_W'(RAS_MIN_CYC - 1)) begin
					next_state = self_go ? S_SELF : S_PRE;
					next_cnt = '0;
				end
			end
			S_SELF: begin
				// saturate; exit only after the entry pulse time is met
				if (cnt >= CNT_W'(SELF_HOLD_CYCLES - 1)) begin
					next_cnt = cnt;
					if (!sleep_i) begin
						next_state = S_PRE;
						next_cnt = '0;
						next_self_go = 1'b0;
						next_burst_left = BURST_W'(REF_ROWS);
					end
				end
			end
			default: begin
				next_state = S_IDLE;
			end
		endcase
		next_ready = (next_state == S_IDLE || next_state == S_PAGE) && !next_pend && !next_ref_pend
			&& !sleep_i && next_burst_left == '0;
	end

	// pin values follow the state being entered
	always_comb begin
		next_pins = pins;
		next_pins.ras_n = 1'b1;
		next_pins.lower_lane_column_strobe_n_n = 1'b1;
		next_pins.upper_lane_column_strobe_n_n = 1'b1;
		next_pins.we_n = 1'b1;
		next_pins.oe_n = 1'b1;
		next_pins.dq_oe = 2'h0;
		case (next_state)
			S_ROW: begin
				next_pins.ras_n = 1'b0;
				next_pins.addr = next_cur.addr[2*ADDR_W-1:ADDR_W];
			end
			S_COL: begin
				next_pins.ras_n = 1'b0;
				next_pins.addr = next_cur.addr[ADDR_W-1:0];
				// an empty lane mask still needs one strobe to finish the cycle
				next_pins.lower_lane_column_strobe_n_n = !(next_cur.be[0] || next_cur.be == 2'h0);
				next_pins.upper_lane_column_strobe_n_n = !next_cur.be[1];
				next_pins.we_n = !next_cur.wr;
				next_pins.oe_n = next_cur.wr;
				next_pins.dq = next_cur.wdata;
				if (next_cur.wr) begin
					next_pins.dq_oe = {!next_pins.upper_lane_column_strobe_n_n, !next_pins.lower_lane_column_strobe_n_n};
				end
			end
			S_PAGE: begin
				next_pins.ras_n = 1'b0;
			end
			S_CBR_CAS: begin
				next_pins.lower_lane_column_strobe_n_n = 1'b0;
				next_pins.upper_lane_column_strobe_n_n = 1'b0;
			end
			S_CBR_RAS, S_SELF: begin
				next_pins.ras_n = 1'b0;
				next_pins.lower_lane_column_strobe_n_n = 1'b0;
				next_pins.upper_lane_column_strobe_n_n = 1'b0;
			end
			default: begin
				next_pins.ras_n = 1'b1;
			end
		endcase
	end

	// state registers; reset holds every strobe high from the start
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state <= S_PAUSE;
			cnt <= '0;
			ras_cnt <= '0;
			burst_left <= '0;
			open_row <= '0;
			cur <= '0;
			pend <= 1'b0;
			ref_pend <= 1'b0;
			self_go <= 1'b0;
			pins <= '{ras_n: 1'b1, lower_lane_column_strobe_n_n: 1'b1, upper_lane_column_strobe_n_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
			req_ready_o <= 1'b0;
			rsp_valid_o <= 1'b0;
			rdata_o <= '0;
			self_refresh_o <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			ras_cnt <= next_ras_cnt;
			burst_left <= next_burst_left;
			open_row <= next_open_row;
			cur <= next_cur;
			pend <= next_pend;
			ref_pend <= next_ref_pend;
			self_go <= next_self_go;
			pins <= next_pins;
			req_ready_o <= next_ready;
			rsp_valid_o <= next_rsp_valid;
			rdata_o <= next_rdata;
			self_refresh_o <= next_state == S_SELF;
		end
	end

	// data pins come from the device's own timing, so two stages first
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dq_s1 <= '0;
			dq_s2 <= '0;
		end else begin
			dq_s1 <= data_lines_i;
			dq_s2 <= dq_s1;
		end
	end

	// checks on the driven pins and the refresh schedule
	localparam int GAP_MAX = REF_CYC + RAS_MAX_CYC + 16;
	logic [CNT_W-1:0] ref_gap;
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ref_gap <= '0;
		end else begin
			ref_gap <= (state == S_CBR_CAS || state == S_PAUSE || state == S_SELF) ? '0 : ref_gap + 1'b1;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	property p_mux_addr;
		$fell(ras_n_o) && lower_lane_column_strobe_n_o && upper_lane_column_strobe_n_o
			|-> mux_address_lines_o == open_row ##1 mux_address_lines_o == cur.addr[ADDR_W-1:0];
	endproperty
	a_mux_addr: assert property (p_mux_addr) else $error("row then column not on shared lines");

	property p_ras_min;
		$fell(ras_n_o) |-> !ras_n_o [*2];
	endproperty
	a_ras_min: assert property (p_ras_min) else $error("row strobe pulse too short");

	property p_cycle_end;
		$rose(ras_n_o) |-> lower_lane_column_strobe_n_o && upper_lane_column_strobe_n_o && we_n_o;
	endproperty
	a_cycle_end: assert property (p_cycle_end) else $error("cycle ended with a strobe low");

	property p_read;
		// the column goes out on the first read cycle, so hold is checked from the second on
		!oe_n_o |-> we_n_o && !ras_n_o && data_lines_oe_o == 2'h0
			&& ($past(oe_n_o) || $stable(mux_address_lines_o));
	endproperty
	a_read: assert property (p_read) else $error("read without write strobe high");

	property p_wdata;
		!we_n_o |-> data_lines_oe_o == ~{upper_lane_column_strobe_n_o, lower_lane_column_strobe_n_o};
	endproperty
	a_wdata: assert property (p_wdata) else $error("write data not driven with strobe");

	property p_cbr;
		$fell(ras_n_o) && !lower_lane_column_strobe_n_o
			|-> !$past(lower_lane_column_strobe_n_o) && !$past(upper_lane_column_strobe_n_o) && we_n_o;
	endproperty
	a_cbr: assert property (p_cbr) else $error("refresh without column strobes first");

	property p_ref_gap;
		ref_gap < CNT_W'(GAP_MAX);
	endproperty
	a_ref_gap: assert property (p_ref_gap) else $error("refresh interval exceeded");

	property p_init;
		state == S_PAUSE |-> ras_n_o && lower_lane_column_strobe_n_o && upper_lane_column_strobe_n_o && we_n_o;
	endproperty
	a_init: assert property (p_init) else $error("strobe low during power-on pause");

	property p_init_burst;
		state == S_PAUSE ##1 state != S_PAUSE |-> burst_left == BURST_W'(INIT_CYCLES);
	endproperty
	a_init_burst: assert property (p_init_burst) else $error("wake-up cycles not scheduled");

	property p_self_exit;
		state == S_SELF ##1 state != S_SELF |-> ras_n_o && burst_left == BURST_W'(REF_ROWS);
	endproperty
	a_self_exit: assert property (p_self_exit) else $error("bad self refresh exit");

	c_read: cover property (state == S_COL && col_last && !cur.wr);
	c_write: cover property (state == S_COL && col_last && cur.wr);
	c_page_hit: cover property (state == S_PAGE ##1 state == S_COL);
	c_self: cover property (state == S_SELF ##1 state == S_PRE);
endmodule : edp_ctrl

// ===== test/edp_dram_model.sv
// Purpose: behavioural page-mode dram standing on the pin side of the host controller
// Assumes: controller strobes move together on its clock edges; sampled 1 ns later
// Notes: counts refreshes, row opens and host timing slips for the bench
`timescale 1ns/1ps
module edp_dram_model import edp_pkg::*; #(
	parameter int ACC_NS = 14
) (
	input wire logic ras_n_i,
	input wire logic lower_lane_column_strobe_n_n_i,
	input wire logic upper_lane_column_strobe_n_n_i,
	input wire logic we_n_i,
	input wire logic oe_n_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] dq_i,
	input wire logic [1:0] host_oe_i,
	output logic [DATA_W-1:0] dq_o,
	output int cbr_cnt_o = 0,
	output int open_cnt_o = 0,
	output int viol_cnt_o = 0
);
	logic [DATA_W-1:0] mem [int];
	logic [DATA_W-1:0] rd = '0;
	logic [1:0] drv = '0;
	logic [1:0] lanes;
	logic [ADDR_W-1:0] row = '0;
	logic column_before_row_refresh = 1'b0;
	realtime t_fall = 0;
	realtime t_rise = 0;
	int key;
	// device strobe: first lane falling to last lane rising
	wire cas_n = lower_lane_column_strobe_n_n_i & upper_lane_column_strobe_n_n_i;
	// released lanes show the inverse of the last value, never a stale copy
	assign dq_o = {drv[1] ? rd[15:8] : ~rd[15:8], drv[0] ? rd[7:0] : ~rd[7:0]};

	// row strobe fall opens a row or starts a column-before-row refresh
	always @(negedge ras_n_i) begin
		#1;
		if ($realtime - t_rise < T_RP_NS) viol_cnt_o++;
		t_fall = $realtime;
		column_before_row_refresh = ~cas_n;
		if (column_before_row_refresh) cbr_cnt_o++; // internal counter row, address ignored
		else begin
			row = addr_i;
			open_cnt_o++;
		end
	end
	// the x-to-high edge at start is not a real pulse
	always @(posedge ras_n_i) begin
		#1;
		if (t_fall > 0 && $realtime - t_fall < T_RAS_NS) viol_cnt_o++;
		t_rise = $realtime;
		column_before_row_refresh = 1'b0;
	end
	// a new column strobe ends the held read data
	always @(negedge cas_n) begin
		#1;
		if (!ras_n_i && !column_before_row_refresh) begin
			drv = '0;
			lanes = ~{upper_lane_column_strobe_n_n_i, lower_lane_column_strobe_n_n_i};
			key = int'({row, addr_i});
			if (!we_n_i) begin
				if ((host_oe_i & lanes) != lanes) viol_cnt_o++;
				if (!mem.exists(key)) mem[key] = '0;
				if (lanes[0]) mem[key][7:0] = dq_i[7:0];
				if (lanes[1]) mem[key][15:8] = dq_i[15:8];
			end else if (!oe_n_i) begin
				#(ACC_NS - 1);
				rd = mem.exists(key) ? mem[key] : '0;
				drv = lanes;
			end
		end
	end
	// output strobe high takes the lanes off the lines
	always @(posedge oe_n_i) drv = '0;
	// refresh-only cycles must never see host data on the lines
	always @(host_oe_i or column_before_row_refresh) if (column_before_row_refresh && host_oe_i != '0) viol_cnt_o++;
endmodule : edp_dram_model

// ===== test/testbench.sv
// Purpose: self-checking bench for the page-mode dram host controller
// Assumes: pause and self refresh hold shortened by parameter
// Notes: reference memory of integers checks every read result
`timescale 1ns/1ps
module testbench import edp_pkg::*;;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic req_valid_i = 1'b0;
	edp_req_t req_i = '0;
	logic sleep_i = 1'b0;
	logic req_ready_o, rsp_valid_o, self_refresh_o, ras_n, lower_lane_column_strobe_n_n, upper_lane_column_strobe_n_n, we_n, oe_n;
	logic [DATA_W-1:0] rdata, d_out, m_dq, bus;
	logic [ADDR_W-1:0] addr;
	logic [1:0] d_oe;
	int cbr_cnt, open_cnt, viol_cnt;
	int error_cnt = 0;
	int checked = 0;
	logic [15:0] ref_mem [int];
	logic [19:0] pool [8];

	always #20 clk_i = ~clk_i;
	// host wins a lane only while it enables it
	assign bus = {d_oe[1] ? d_out[15:8] : m_dq[15:8], d_oe[0] ? d_out[7:0] : m_dq[7:0]};

	edp_ctrl #(.PAUSE_CYCLES(20), .SELF_HOLD_CYCLES(4)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
		.rdata_o(rdata), .sleep_i(sleep_i), .self_refresh_o(self_refresh_o), .ras_n_o(ras_n),
		.lower_lane_column_strobe_n_o(lower_lane_column_strobe_n_n), .upper_lane_column_strobe_n_o(upper_lane_column_strobe_n_n), .we_n_o(we_n),
		.oe_n_o(oe_n), .mux_address_lines_o(addr), .data_lines_i(bus), .data_lines_o(d_out),
		.data_lines_oe_o(d_oe));
	edp_dram_model mem_u (.ras_n_i(ras_n), .lower_lane_column_strobe_n_n_i(lower_lane_column_strobe_n_n), .upper_lane_column_strobe_n_n_i(upper_lane_column_strobe_n_n), .we_n_i(we_n),
		.oe_n_i(oe_n), .addr_i(addr), .dq_i(bus), .host_oe_i(d_oe), .dq_o(m_dq), .cbr_cnt_o(cbr_cnt),
		.open_cnt_o(open_cnt), .viol_cnt_o(viol_cnt));

	task end_sim;
		if (error_cnt == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t ns: saw %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// bounded wait at falling edges: 0 ready, 1 response, 2 self refresh
	task wait_flag(input int sel, input int lim);
		int n;
		for (n = 0; n < lim; n++) begin
			if ((sel == 0 && req_ready_o === 1'b1) || (sel == 1 && rsp_valid_o === 1'b1) ||
				(sel == 2 && self_refresh_o === 1'b1)) break;
			@(negedge clk_i);
		end
		if (n == lim) begin
			error_cnt++;
			$display("CHECK FAILED at %0t ns: wait ran out", $time);
			end_sim;
		end
	endtask : wait_flag

	// request held until taken; reads compared on enabled lanes only
	task access(input logic wr, input logic [1:0] be, input logic [19:0] a, input logic [15:0] d);
		logic [15:0] m;
		m = {{8{be[1]}}, {8{be[0]}}};
		@(negedge clk_i);
		req_i = '{wr, be, a, d};
		req_valid_i = 1'b1;
		wait_flag(0, 20000);
		@(negedge clk_i);
		req_valid_i = 1'b0;
		wait_flag(1, 50);
		if (wr) ref_mem[a] = (ref_mem[a] & ~m) | (d & m);
		else check(rdata & m, ref_mem[a] & m);
	endtask : access

	initial begin
		int c0;
		int o0;
		void'($urandom(53));
		for (int i = 0; i < 8; i++) pool[i] = {(i < 4) ? 10'h005 : 10'h3FF, (i == 7) ? 10'h3FF : 10'($urandom)};
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		rstn_i = 1'b1;
		// pause: strobes high, nothing issued yet
		repeat (10) @(negedge clk_i);
		check({ras_n, lower_lane_column_strobe_n_n, upper_lane_column_strobe_n_n, we_n, req_ready_o}, 5'h1E);
		check(cbr_cnt, 0);
		wait_flag(0, 500);
		check(cbr_cnt >= 8, 1);
		// whole words first, then random byte and word traffic over two rows
		for (int i = 0; i < 8; i++) access(1'b1, 2'h3, pool[i], 16'($urandom));
		for (int i = 0; i < 60; i++) access(1'($urandom), 2'(1 + $urandom % 3), pool[$urandom % 8], 16'($urandom));
		// same row back to back stays inside one row cycle
		c0 = cbr_cnt;
		o0 = open_cnt;
		for (int i = 0; i < 4; i++) access(1'b0, 2'h3, pool[i], 16'h0000);
		check(open_cnt - o0 <= 1 + cbr_cnt - c0, 1);
		// idle: distributed refresh alone
		c0 = cbr_cnt;
		repeat (800) @(negedge clk_i);
		check((cbr_cnt - c0 >= 2) && (cbr_cnt - c0 <= 3), 1);
		// self refresh: enter, hold, leave, then the full row burst
		sleep_i = 1'b1;
		wait_flag(2, 300);
		check({ras_n, lower_lane_column_strobe_n_n, upper_lane_column_strobe_n_n}, 3'h0);
		repeat (10) @(negedge clk_i);
		check({ras_n, req_ready_o}, 2'h0);
		c0 = cbr_cnt;
		sleep_i = 1'b0;
		wait_flag(0, 20000);
		check(cbr_cnt - c0 >= REF_ROWS, 1);
		for (int i = 0; i < 8; i++) access(1'b0, 2'h3, pool[i], 16'h0000);
		// reset in mid-run puts every strobe back high at once
		@(negedge clk_i);
		rstn_i = 1'b0;
		#1;
		check({ras_n, lower_lane_column_strobe_n_n, upper_lane_column_strobe_n_n, we_n, oe_n, d_oe, req_ready_o, rsp_valid_o, self_refresh_o}, 10'h3E0);
		c0 = cbr_cnt;
		repeat (2) @(negedge clk_i);
		rstn_i = 1'b1;
		wait_flag(0, 500);
		check(cbr_cnt - c0 >= 8, 1);
		check(viol_cnt, 0);
		end_sim;
	end
endmodule : testbench
